// ==== design/xps_config_port.sv ====
// Configuration port of an 8x8 video crosspoint: strobe-driven command decoder,
// first-rank chain and control of the second-rank store.
// Assumes all strobes and code pins are asynchronous to clk_sys and change slowly
// compared with the 10 ns clock; each pin passes two flip-flops before use.
`timescale 1ns/10ps
`default_nettype none

module xps_config_port
    import xps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic interface_select,
    input wire logic write_strobe,
    input wire logic transfer_strobe,
    input wire logic transfer_edge_select,
    input wire logic chip_select,
    input wire logic chip_select_n,
    input wire logic [2:0] output_select_lines,
    input wire logic [3:0] code_lines,
    output logic code_line_one_out,
    output logic code_line_one_oe,
    output logic [23:0] video_route_sel,
    output logic [7:0] video_ground,
    output logic [7:0] buffer_enable
);
    localparam int PIN_W = 13;

    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_sync_r;
    logic wr_prev_r;
    logic xfer_prev_r;
    logic ser_mode;
    logic wr_lvl;
    logic xfer_lvl;
    logic edge_sel;
    logic cs_hi;
    logic cs_lo_n;
    logic [2:0] out_sel;
    logic [3:0] code;
    logic wr_rise;
    logic xfer_rise;
    logic par_write;
    logic ser_write;
    logic sw_xfer;
    logic xfer_req;
    logic chain_bad;
    logic [`XPS_CHAIN_BITS-1:0] chain_r;
    logic [`XPS_CHAIN_BITS-1:0] chain_nxt;
    logic ser_out_r;

    xps_rank_if rk_if ();

    xps_rank u_rank (
        .clk_sys(clk_sys),
        .reset(reset),
        .rk(rk_if.store)
    );

    // Two-stage synchronisers; only the second stage feeds logic
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {interface_select, write_strobe, transfer_strobe, transfer_edge_select,
                           chip_select, chip_select_n, output_select_lines, code_lines};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign ser_mode = pin_sync_r[12];
    assign wr_lvl = pin_sync_r[11];
    assign xfer_lvl = pin_sync_r[10];
    assign edge_sel = pin_sync_r[9];
    assign cs_hi = pin_sync_r[8];
    assign cs_lo_n = pin_sync_r[7];
    assign out_sel = pin_sync_r[6:4];
    assign code = pin_sync_r[3:0];

    // Edge memories start high, but the synchronisers reset low, so a strobe already high at reset release still gives one edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_prev_r <= 1'b1;
            xfer_prev_r <= 1'b1;
        end else begin
            wr_prev_r <= wr_lvl;
            xfer_prev_r <= xfer_lvl;
        end
    end

    // Chip selects gate the write strobe edge itself
    assign wr_rise = wr_lvl && !wr_prev_r && cs_hi && !cs_lo_n;
    assign xfer_rise = xfer_lvl && !xfer_prev_r;
    assign par_write = wr_rise && !ser_mode;
    assign ser_write = wr_rise && ser_mode;

    // Code bit three picks control code versus input number
    assign sw_xfer = par_write && code == `XPS_CODE_SW_XFER;

    // First rank: serial shifting through the whole chain, or one addressed entry
    always_comb begin
        chain_nxt = chain_r;
        if (ser_write) begin
            // Data in on code bit zero, fields arrive MSB first, output zero first
            chain_nxt = {chain_r[`XPS_CHAIN_BITS-2:0], code[0]};
        end else if (par_write && (!code[3] || code == `XPS_CODE_GROUND)) begin
            // Only the addressed entry changes route or ground codes
            chain_nxt[(`XPS_NUM_OUT - 1 - out_sel) * `XPS_CODE_BITS +: `XPS_CODE_BITS] = code;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chain_r <= `XPS_RST_CHAIN;
        end else begin
            chain_r <= chain_nxt;
        end
    end

    // Bit leaving the far end of the chain drives the cascade output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ser_out_r <= 1'b0;
        end else if (ser_write) begin
            ser_out_r <= chain_r[`XPS_CHAIN_BITS-1];
        end
    end

    assign code_line_one_out = ser_out_r;
    assign code_line_one_oe = ser_mode;

    // Map chain fields to outputs: field of output zero sits at the top
    genvar gi;
    generate
        for (gi = 0; gi < `XPS_NUM_OUT; gi++) begin : g_field
            assign rk_if.first_rank[gi] =
                chain_r[(`XPS_NUM_OUT - 1 - gi) * `XPS_CODE_BITS +: `XPS_CODE_BITS];
        end
    endgenerate

    // Serial codes 1011 and up inhibit the second-rank transfer
    always_comb begin
        chain_bad = 1'b0;
        for (int i = 0; i < `XPS_NUM_OUT; i++) begin
            if (rk_if.first_rank[i] >= `XPS_CODE_FIRST_BAD) begin
                chain_bad = 1'b1;
            end
        end
    end

    // Edge mode loads on the rise; level mode follows while the strobe is low
    // The software transfer pulse stands in for a strobe pulse
    assign xfer_req = (edge_sel ? xfer_rise : !xfer_lvl) || sw_xfer;
    // A parallel first rank never holds 1011 and up, so the inhibit only bites in
    // serial mode; after a mode switch, stale serial codes 1011 and up load without blocking
    assign rk_if.load = xfer_req && !(ser_mode && chain_bad);

    // Parallel enable commands act at once on the buffers
    always_comb begin
        rk_if.en_set = '0;
        rk_if.en_clr = '0;
        if (par_write) begin
            unique case (code)
                `XPS_CODE_PAR_OFF: rk_if.en_clr[out_sel] = 1'b1;
                `XPS_CODE_PAR_ON: rk_if.en_set[out_sel] = 1'b1;
                `XPS_CODE_ALL_OFF: rk_if.en_clr = '1;
                `XPS_CODE_ALL_ON: rk_if.en_set = '1;
                default: ;
            endcase
        end
    end

    // Outputs come straight from second-rank flip-flops
    generate
        for (gi = 0; gi < `XPS_NUM_OUT; gi++) begin : g_drive
            // Input number for codes 0000-0111
            assign video_route_sel[gi*3 +: 3] = rk_if.code[gi][2:0];
        end
    endgenerate

    assign video_ground = rk_if.grounded;
    assign buffer_enable = rk_if.buf_en;
endmodule

`default_nettype wire

// ==== design/xps_defines.svh ====
// Constants of the crosspoint switch configuration port: sizes, codes, reset values.
// Assumes inclusion by every design file that decodes codes or sizes the ranks.
//
// Contract
// - Serial field 0000-0111 selects that numbered input for its output.
// - Serial field 1000 grounds buffer input, buffer on/off unchanged.
// - Serial field 1001 enables the buffer and grounds its input.
// - All output buffers start disabled after reset.
// - Serial field 1010 disables buffer; second-rank entry then holds 1010.
// - Any serial field 1011-1111 blocks transfer into the second rank; the code blocks in serial mode only, so stale fields load in parallel mode.
// - Parallel: code bit three high means control code, low means input number.
// - Presented word is captured into the first rank on write strobe rise.
// - Transfer strobe rise copies first rank to second; all outputs change together.
// - A parallel write alters only the addressed output's first-rank entry.
// - Write strobe acts only with chip select high and inverted select low.
// - Edge select high: load on transfer rise; low: follow while strobe low.
// - Serial word is 32 bits, 4-bit fields MSB first, output zero first.
// - Parallel 1011 off, 1100 on, 1101 all off, 1110 all on, 1111 transfer.
`ifndef XPS_DEFINES_SVH
`define XPS_DEFINES_SVH

`define XPS_NUM_OUT 8
`define XPS_CODE_BITS 4
`define XPS_CHAIN_BITS 32

`define XPS_CODE_GROUND 4'h8
`define XPS_CODE_SER_ON 4'h9
`define XPS_CODE_SER_OFF 4'ha
`define XPS_CODE_PAR_OFF 4'hb
`define XPS_CODE_PAR_ON 4'hc
`define XPS_CODE_ALL_OFF 4'hd
`define XPS_CODE_ALL_ON 4'he
`define XPS_CODE_SW_XFER 4'hf
`define XPS_CODE_FIRST_BAD 4'hb

`define XPS_RST_CODE 4'h0
`define XPS_RST_EN 8'h00
`define XPS_RST_CHAIN 32'h0000_0000

`endif

// ==== design/xps_pkg.sv ====
// Types shared by the configuration port and its second-rank store.
// Assumes xps_defines.svh is on the include path.
`include "xps_defines.svh"

package xps_pkg;
    typedef logic [`XPS_CODE_BITS-1:0] xps_code_t;
    typedef xps_code_t [`XPS_NUM_OUT-1:0] xps_bank_t;
    typedef logic [`XPS_NUM_OUT-1:0] xps_mask_t;
endpackage

// ==== design/xps_rank_if.sv ====
// Link between the command decoder and the second-rank store.
// Assumes both ends run on clk_sys.
`timescale 1ns/10ps
`default_nettype none

interface xps_rank_if;
    import xps_pkg::*;
    logic load;
    xps_bank_t first_rank;
    xps_mask_t en_set;
    xps_mask_t en_clr;
    xps_bank_t code;
    xps_mask_t buf_en;
    xps_mask_t grounded;
    modport feed (output load, output first_rank, output en_set, output en_clr,
                  input code, input buf_en, input grounded);
    modport store (input load, input first_rank, input en_set, input en_clr,
                   output code, output buf_en, output grounded);
endinterface

`default_nettype wire

// ==== design/xps_rank.sv ====
// Second-rank registers with buffer enables and ground flags.
// Assumes load is already cleared of blocking codes in serial mode; in level mode it stays high while the strobe is low.
`timescale 1ns/10ps
`default_nettype none

module xps_rank
    import xps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    xps_rank_if.store rk
);
    genvar gi;
    generate
        for (gi = 0; gi < `XPS_NUM_OUT; gi++) begin : g_out
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    rk.code[gi] <= `XPS_RST_CODE;
                    rk.grounded[gi] <= 1'b0;
                end else if (rk.load) begin
                    // Entry keeps the raw code, so a disable leaves 1010 behind
                    rk.code[gi] <= rk.first_rank[gi];
                    rk.grounded[gi] <= rk.first_rank[gi][3];
                end
            end

            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    rk.buf_en[gi] <= 1'b0;
                end else if (rk.load && rk.first_rank[gi] == `XPS_CODE_SER_ON) begin
                    rk.buf_en[gi] <= 1'b1;
                end else if (rk.load && rk.first_rank[gi] == `XPS_CODE_SER_OFF) begin
                    rk.buf_en[gi] <= 1'b0;
                end else if (rk.en_set[gi]) begin
                    rk.buf_en[gi] <= 1'b1;
                end else if (rk.en_clr[gi]) begin
                    rk.buf_en[gi] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// ==== bench/xps_config_port_asserts.sv ====
// Checker on the configuration port pins and outputs.
// Assumes strobes hold each level for at least 3 clocks.
`timescale 1ns/10ps
`default_nettype none
module xps_config_port_asserts (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic interface_select,
    input wire logic write_strobe,
    input wire logic transfer_strobe,
    input wire logic transfer_edge_select,
    input wire logic chip_select,
    input wire logic chip_select_n,
    input wire logic [3:0] code_lines,
    input wire logic code_line_one_out,
    input wire logic code_line_one_oe,
    input wire logic [23:0] video_route_sel,
    input wire logic [7:0] video_ground,
    input wire logic [7:0] buffer_enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic wen = chip_select && !chip_select_n;
    wire logic quiet = transfer_edge_select && !transfer_strobe;
    property p_rst;
        $fell(reset) |-> buffer_enable == 8'h00 && video_ground == 8'h00 && video_route_sel == 24'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_oe;
        $stable(interface_select)[*6] |-> code_line_one_oe == interface_select;
    endproperty
    a_oe: assert property (p_oe) else $error("serial out enable wrong");
    property p_hold;
        (quiet && !write_strobe)[*6] |-> $stable({video_route_sel, video_ground});
    endproperty
    a_hold: assert property (p_hold) else $error("routing moved without transfer");
    property p_en;
        (quiet && !write_strobe)[*6] |-> $stable(buffer_enable);
    endproperty
    a_en: assert property (p_en) else $error("enables moved without strobe");
    property p_sout;
        (!write_strobe)[*6] |-> $stable(code_line_one_out);
    endproperty
    a_sout: assert property (p_sout) else $error("serial out moved without write");
    property p_cs;
        (quiet && !wen)[*8] |-> $stable({buffer_enable, code_line_one_out});
    endproperty
    a_cs: assert property (p_cs) else $error("write acted while deselected");
    property p_on;
        $rose(write_strobe) && wen && !interface_select && code_lines == 4'he |-> ##[1:5] buffer_enable == 8'hff;
    endproperty
    a_on: assert property (p_on) else $error("all-on command failed");
    property p_off;
        $rose(write_strobe) && wen && !interface_select && code_lines == 4'hd |-> ##[1:5] buffer_enable == 8'h00;
    endproperty
    a_off: assert property (p_off) else $error("all-off command failed");
endmodule
bind xps_config_port xps_config_port_asserts xps_config_port_asserts_i (.clk_sys, .reset, .interface_select,
    .write_strobe, .transfer_strobe, .transfer_edge_select, .chip_select, .chip_select_n, .code_lines,
    .code_line_one_out, .code_line_one_oe, .video_route_sel, .video_ground, .buffer_enable);
`default_nettype wire

// ==== bench/xps_host_model.sv ====
// Host side: a printer-port style driver of strobes, selects and code lines.
// Assumes the bench calls its tasks; pins change on the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module xps_host_model (
    input wire logic clk_sys,
    input wire logic code_line_one_out,
    input wire logic code_line_one_oe,
    output logic interface_select = 1'b0,
    output logic write_strobe = 1'b0,
    output logic transfer_strobe = 1'b0,
    output logic transfer_edge_select = 1'b1,
    output logic chip_select = 1'b1,
    output logic chip_select_n = 1'b0,
    output logic [2:0] output_select_lines = 3'h0,
    output logic [3:0] code_lines
);
    logic [3:0] drv = 4'h0;
    // Bit one belongs to the device while it drives it
    assign code_lines = {drv[3:2], code_line_one_oe ? code_line_one_out : drv[1], drv[0]};
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Parallel callers never pass 1001 or 1010
    task automatic wr(input logic [2:0] s, input logic [3:0] c);
        tick(1);
        output_select_lines = s;
        drv = c;
        tick(4);
        write_strobe = 1'b1;
        tick(6);
        write_strobe = 1'b0;
        tick(6);
    endtask
    // Unused pins toggle on every serial bit
    task automatic ser(input logic d);
        wr(~output_select_lines, {~drv[3:1], d});
    endtask
    task automatic xfer();
        tick(1);
        transfer_strobe = 1'b1;
        tick(6);
        transfer_strobe = 1'b0;
        tick(6);
    endtask
endmodule
`default_nettype wire

// ==== bench/xps_config_port_tb.sv ====
// Self-checking bench of the configuration port, driven through the host model.
// Assumes the design's 3-clock pin latency; waits are fixed counts.
`timescale 1ns/10ps
`default_nettype none
module xps_config_port_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    wire logic interface_select, write_strobe, transfer_strobe, transfer_edge_select;
    wire logic chip_select, chip_select_n, code_line_one_out, code_line_one_oe;
    wire logic [2:0] output_select_lines;
    wire logic [3:0] code_lines;
    wire logic [23:0] video_route_sel;
    wire logic [7:0] video_ground, buffer_enable;
    int num_errors = 0;
    int checks = 0;
    logic [23:0] r = 24'h0;
    logic [6:0] cmd [4] = '{7'h0e, 7'h3b, 7'h0d, 7'h5c};
    logic [7:0] en [4] = '{8'hff, 8'hf7, 8'h00, 8'h20};
    always #5 clk_sys = ~clk_sys;
    xps_config_port xps_config_port_i (.clk_sys, .reset, .interface_select, .write_strobe, .transfer_strobe,
        .transfer_edge_select, .chip_select, .chip_select_n, .output_select_lines, .code_lines,
        .code_line_one_out, .code_line_one_oe, .video_route_sel, .video_ground, .buffer_enable);
    xps_host_model xps_host_model_i (.clk_sys, .code_line_one_out, .code_line_one_oe, .interface_select,
        .write_strobe, .transfer_strobe, .transfer_edge_select, .chip_select, .chip_select_n,
        .output_select_lines, .code_lines);
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        checks++;
        if (g !== e) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
            num_errors++;
        end
    endtask
    task automatic results();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge clk_sys);
        reset = 1'b1;
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({buffer_enable, video_ground, video_route_sel}, 40'h0);
        chk(code_line_one_oe, 1'b0);
        $display("reset test done");
    endtask
    task automatic send(input logic [31:0] v, input logic [31:0] prev, input logic ck);
        for (int i = 31; i >= 0; i--) begin
            xps_host_model_i.ser(v[i]);
            if (ck) chk(code_line_one_out, prev[i]);
        end
    endtask
    initial begin
        do_reset();
        // Every output written, then one transfer moves them together
        for (int k = 0; k < 8; k++) begin
            xps_host_model_i.wr(k[2:0], 4'(7 - k));
            r[3*k +: 3] = 3'(7 - k);
        end
        chk(video_route_sel, 24'h0);
        xps_host_model_i.xfer();
        chk(video_route_sel, r);
        xps_host_model_i.wr(3'h2, 4'h8);
        xps_host_model_i.xfer();
        r[8:6] = 3'h0;
        chk({video_ground, video_route_sel}, {8'h04, r});
        xps_host_model_i.chip_select = 1'b0;
        xps_host_model_i.wr(3'h0, 4'he);
        chk(buffer_enable, 8'h00);
        xps_host_model_i.chip_select = 1'b1;
        foreach (cmd[i]) begin
            xps_host_model_i.wr(cmd[i][6:4], cmd[i][3:0]);
            chk(buffer_enable, en[i]);
        end
        xps_host_model_i.wr(3'h0, 4'h1);
        xps_host_model_i.wr(3'h7, 4'hf);
        chk(video_route_sel[2:0], 3'h1);
        $display("parallel test done");
        xps_host_model_i.interface_select = 1'b1;
        send(32'h9a83_4567, 32'h0, 1'b0);
        chk(code_line_one_oe, 1'b1);
        xps_host_model_i.xfer();
        chk({buffer_enable, video_ground, video_route_sel}, 40'h21_07_fac611);
        send(32'h0000_000b, 32'h9a83_4567, 1'b1);
        xps_host_model_i.xfer();
        chk({buffer_enable, video_ground, video_route_sel}, 40'h21_07_fac611);
        $display("serial test done");
        xps_host_model_i.transfer_strobe = 1'b1;
        xps_host_model_i.transfer_edge_select = 1'b0;
        xps_host_model_i.interface_select = 1'b0;
        xps_host_model_i.wr(3'h4, 4'h6);
        chk(video_route_sel, 24'hfac611);
        xps_host_model_i.transfer_strobe = 1'b0;
        xps_host_model_i.tick(6);
        chk({video_ground, video_route_sel}, 32'h80_606000);
        xps_host_model_i.transfer_edge_select = 1'b1;
        $display("level test done");
        do_reset();
        results();
    end
endmodule
`default_nettype wire
